// file: include/lad_pkg.sv
// package: constants, types and helpers of the legacy address decoder
package lad_pkg;
	localparam int ADDR_W = 36;
	localparam int IO_W = 17;
	localparam int NSEG = 13;
	localparam int SEG_SHIFT = 14;
	localparam int MB_SHIFT = 20;
	localparam logic [3:0] BIOS_SEG = 4'hc;
	// memory map below 1 MB and above 4 GB, and the top of io space
	localparam logic [35:0] DOS_HI = 36'h00009ffff;
	localparam logic [35:0] VID_LO = 36'h0000a0000;
	localparam logic [35:0] VID_HI = 36'h0000bffff;
	localparam logic [35:0] MONO_LO = 36'h0000b0000;
	localparam logic [35:0] MONO_HI = 36'h0000b7fff;
	localparam logic [35:0] SEG_LO = 36'h0000c0000;
	localparam logic [35:0] BIOS_LO = 36'h0000f0000;
	localparam logic [35:0] SEG_HI = 36'h0000fffff;
	localparam logic [35:0] HIGH_LO = 36'h100000000;
	localparam logic [35:0] IO_TOP = 36'h000010002;
	// register offsets, fields and reset values
	localparam logic [11:0] RA_SEG_RE = 12'h000;
	localparam logic [11:0] RA_SEG_WE = 12'h004;
	localparam logic [11:0] RA_VIDEO = 12'h008;
	localparam logic [11:0] RA_TOM = 12'h00c;
	localparam logic [11:0] RA_STAT = 12'h010;
	localparam int VB_IGU = 0;
	localparam int VB_VGA = 1;
	localparam int VB_MONO = 2;
	localparam int VB_SMRAM = 3;
	localparam logic [12:0] SEG_RST = 13'h0000;
	localparam logic [11:0] TOM_RST = 12'h000;
	localparam logic [11:0] TOM_MAX = 12'h800;
	// cycle sources
	localparam logic [1:0] SRC_CPU = 2'h0;
	localparam logic [1:0] SRC_GPB = 2'h1;
	localparam logic [1:0] SRC_SOUTH = 2'h2;

	typedef enum logic [2:0] {T_DRAM, T_IGU, T_GPB, T_SOUTH, T_INVALID, T_ABORT, T_LOCAL} lad_tgt_e;
	typedef enum logic [2:0] {RG_DOS, RG_VIDEO, RG_SEG, RG_EXT, RG_HIGH, RG_IO_MONO, RG_IO,
		RG_IO_BAD} lad_rgn_e;

	function automatic logic in_rng(input logic [35:0] a, input logic [35:0] lo,
		input logic [35:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction
endpackage

// file: include/lad_cfg_if.sv
// interface: decoder configuration and status between register file and core
interface lad_cfg_if;
	logic [lad_pkg::NSEG-1:0] seg_re;
	logic [lad_pkg::NSEG-1:0] seg_we;
	logic igu_en;
	logic vga_en;
	logic mono_present;
	logic smram_en;
	logic [11:0] tom;
	logic [2:0] last_tgt;
	logic [7:0] term_cnt;
	modport regs (output seg_re, seg_we, igu_en, vga_en, mono_present, smram_en, tom,
		input last_tgt, term_cnt);
	modport core (input seg_re, seg_we, igu_en, vga_en, mono_present, smram_en, tom,
		output last_tgt, term_cnt);
endinterface

// file: design/lad_region.sv
// region classifier: sorts a cycle address into a legacy map region
module lad_region (
	// cycle address
	input wire logic [lad_pkg::ADDR_W-1:0] addr,
	input wire logic io,
	// classification
	output lad_pkg::lad_rgn_e rgn,
	output logic mono,
	output logic [3:0] seg_idx
);
	always_comb
	begin
		rgn = lad_pkg::RG_EXT;
		mono = 1'b0;
		seg_idx = lad_pkg::BIOS_SEG;
		if (io)
		begin
			// six fixed monochrome ports
			mono = (addr == 36'h0000003b4) || (addr == 36'h0000003b5) || (addr == 36'h0000003b8)
				|| (addr == 36'h0000003b9) || (addr == 36'h0000003ba) || (addr == 36'h0000003bf);
			if (addr > lad_pkg::IO_TOP)
				rgn = lad_pkg::RG_IO_BAD;
			else if (mono)
				rgn = lad_pkg::RG_IO_MONO;
			else
				rgn = lad_pkg::RG_IO;
		end
		else if (addr >= lad_pkg::HIGH_LO)
			rgn = lad_pkg::RG_HIGH;
		else if (addr <= lad_pkg::DOS_HI)
			rgn = lad_pkg::RG_DOS;
		else if (lad_pkg::in_rng(addr, lad_pkg::VID_LO, lad_pkg::VID_HI))
		begin
			rgn = lad_pkg::RG_VIDEO;
			mono = lad_pkg::in_rng(addr, lad_pkg::MONO_LO, lad_pkg::MONO_HI);
		end
		else if (lad_pkg::in_rng(addr, lad_pkg::SEG_LO, lad_pkg::SEG_HI))
		begin
			rgn = lad_pkg::RG_SEG;
			if (addr < lad_pkg::BIOS_LO)
				seg_idx = 4'((addr - lad_pkg::SEG_LO) >> lad_pkg::SEG_SHIFT);
		end
	end
endmodule

// file: design/lad_apb.sv
// apb register file of the legacy address decoder
module lad_apb (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration out, status in
	lad_cfg_if.regs cfg
);
	logic take;
	logic hit;

	// one wait state keeps every apb output on a flop
	assign take = psel && penable && pready;
	assign hit = (paddr == lad_pkg::RA_SEG_RE) || (paddr == lad_pkg::RA_SEG_WE)
		|| (paddr == lad_pkg::RA_VIDEO) || (paddr == lad_pkg::RA_TOM)
		|| (paddr == lad_pkg::RA_STAT);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			prdata <= 32'h00000000;
			if (psel && penable && !pready && !pwrite)
			begin
				case (paddr)
				lad_pkg::RA_SEG_RE: prdata <= {19'h00000, cfg.seg_re};
				lad_pkg::RA_SEG_WE: prdata <= {19'h00000, cfg.seg_we};
				lad_pkg::RA_VIDEO: prdata <= {28'h0000000, cfg.smram_en, cfg.mono_present,
					cfg.vga_en, cfg.igu_en};
				lad_pkg::RA_TOM: prdata <= {20'h00000, cfg.tom};
				lad_pkg::RA_STAT: prdata <= {21'h000000, cfg.term_cnt, cfg.last_tgt};
				default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg.seg_re <= lad_pkg::SEG_RST; // [RL9]
			cfg.seg_we <= lad_pkg::SEG_RST; // [RL9]
			cfg.igu_en <= 1'b0;
			cfg.vga_en <= 1'b0;
			cfg.mono_present <= 1'b0;
			cfg.smram_en <= 1'b0;
			cfg.tom <= lad_pkg::TOM_RST;
		end
		else if (take && pwrite)
		begin
			case (paddr)
			lad_pkg::RA_SEG_RE: cfg.seg_re <= pwdata[lad_pkg::NSEG-1:0]; // [RL10]
			lad_pkg::RA_SEG_WE: cfg.seg_we <= pwdata[lad_pkg::NSEG-1:0]; // [RL10]
			lad_pkg::RA_VIDEO:
			begin
				cfg.igu_en <= pwdata[lad_pkg::VB_IGU];
				cfg.vga_en <= pwdata[lad_pkg::VB_VGA];
				cfg.mono_present <= pwdata[lad_pkg::VB_MONO];
				cfg.smram_en <= pwdata[lad_pkg::VB_SMRAM];
			end
			// populated memory is capped, nothing else limits dram decode
			lad_pkg::RA_TOM: cfg.tom <= (pwdata[11:0] > lad_pkg::TOM_MAX) ? lad_pkg::TOM_MAX
				: pwdata[11:0]; // [RL20]
			default: ;
			endcase
		end
	end
endmodule

// file: design/lad_top.sv
// top of the legacy address decoder: routes cycles below 1 MB, above 4 GB and io
// ****************************************
// Operation
// RL1 - invalid-space writes lose their data, invalid-space reads return zeros
// RL2 - cycles above 4 GB terminate locally: writes dropped, reads zero
// RL3 - memory space is 4 GB, io space 64 kB plus 3 bytes
// RL4 - lowest 640 kB always goes to dram
// RL5 - sixteen segments below 1 MB, thirteen with read and write controls
// RL6 - expansion area is eight 16 kB segments with independent attributes
// RL7 - dram behind a disabled segment is never remapped elsewhere
// RL8 - extended bios area is four 16 kB segments routed dram or south
// RL9 - top bios segment resets read and write disabled, going south
// RL10 - software shadows bios by enabling segment attributes toward dram
// RL11 - video range claims internal devices first, internal graphics highest
// RL12 - then video enable and mono present bit pick bridge or south
// RL13 - smram enabled: management-mode cpu video access goes to dram
// RL14 - smram on, graphics off: bridge cycles abort, south writes bridge
// RL15 - smram on, graphics on: south and bridge cycles are invalid
// RL16 - monochrome memory range routes by steering and mono present bit
// RL17 - six monochrome io ports route like the monochrome memory range
// RL18 - video range is the default system-management ram location
// RL19 - software keeps decode ranges free of overlap; no hardware interlock
// RL20 - at most 2 GB populated, no apic remap, no hardware dram limit
// RL21 - disallowed segment reads or writes are forwarded south, not dram
// ****************************************
//
// Design decisions made here: the address map and the APB interface to the registers.
module lad_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// incoming cycle
	input wire logic cyc_valid,
	input wire logic [lad_pkg::ADDR_W-1:0] cyc_addr,
	input wire logic cyc_io,
	input wire logic cyc_write,
	input wire logic [1:0] cyc_src,
	input wire logic cyc_smm,
	// routing decision
	output logic rt_valid,
	output logic [2:0] rt_target,
	output logic [lad_pkg::ADDR_W-1:0] rt_addr,
	output logic rt_write,
	output logic rt_io,
	output logic rt_rd_zero,
	output logic rt_wr_drop
);
	lad_cfg_if cfg ();
	lad_pkg::lad_rgn_e rgn;
	lad_pkg::lad_tgt_e tgt_nxt;
	lad_pkg::lad_tgt_e plain_tgt;
	lad_pkg::lad_tgt_e video_tgt;
	lad_pkg::lad_tgt_e seg_tgt;
	logic mono;
	logic [3:0] seg_idx;
	logic seg_allow;
	logic below_tom;
	logic term_nxt;

	// ****************************************
	// register file and region classifier
	// ****************************************
	lad_apb u_apb (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cfg(cfg.regs)
	);

	lad_region u_region (
		.addr(cyc_addr),
		.io(cyc_io),
		.rgn(rgn),
		.mono(mono),
		.seg_idx(seg_idx)
	);

	// ****************************************
	// destination decode
	// ****************************************
	// overlapping ranges are not guarded; first match in this order wins [RL19]
	assign below_tom = cyc_addr < (36'(cfg.tom) << lad_pkg::MB_SHIFT); // [RL20]
	assign seg_allow = cyc_write ? cfg.seg_we[seg_idx] : cfg.seg_re[seg_idx]; // [RL5] [RL6] [RL8]

	// steering without smram: internal graphics, then mono, then vga enable
	always_comb
	begin
		if (cfg.igu_en)
			plain_tgt = lad_pkg::T_IGU; // [RL11] [RL16]
		else if (mono && cfg.mono_present)
			plain_tgt = lad_pkg::T_SOUTH; // [RL12] [RL16] [RL17]
		else if (cfg.vga_en)
			plain_tgt = lad_pkg::T_GPB; // [RL12]
		else
			plain_tgt = lad_pkg::T_SOUTH; // [RL12]
	end

	// video range doubles as the compatible smram window [RL18]
	always_comb
	begin
		video_tgt = plain_tgt;
		if (cfg.smram_en)
		begin
			if (cyc_src == lad_pkg::SRC_CPU)
				video_tgt = cyc_smm ? lad_pkg::T_DRAM : plain_tgt; // [RL13]
			else if (cfg.igu_en)
				video_tgt = lad_pkg::T_INVALID; // [RL15]
			else if (cyc_src == lad_pkg::SRC_GPB)
				video_tgt = lad_pkg::T_ABORT; // [RL14]
			else
				video_tgt = cyc_write ? lad_pkg::T_GPB : lad_pkg::T_INVALID; // [RL14]
		end
	end

	// a blocked segment falls through south; its dram stays unreachable [RL7]
	assign seg_tgt = seg_allow ? lad_pkg::T_DRAM : lad_pkg::T_SOUTH; // [RL21] [RL9] [RL10]

	always_comb
	begin
		case (rgn)
		lad_pkg::RG_DOS: tgt_nxt = lad_pkg::T_DRAM; // [RL4]
		lad_pkg::RG_VIDEO: tgt_nxt = video_tgt;
		lad_pkg::RG_SEG: tgt_nxt = seg_tgt;
		lad_pkg::RG_EXT: tgt_nxt = below_tom ? lad_pkg::T_DRAM : lad_pkg::T_SOUTH; // [RL20]
		lad_pkg::RG_HIGH: tgt_nxt = lad_pkg::T_LOCAL; // [RL2]
		lad_pkg::RG_IO_MONO: tgt_nxt = plain_tgt; // [RL17]
		lad_pkg::RG_IO: tgt_nxt = lad_pkg::T_SOUTH;
		lad_pkg::RG_IO_BAD: tgt_nxt = lad_pkg::T_INVALID; // [RL3]
		default: tgt_nxt = lad_pkg::T_SOUTH;
		endcase
	end

	assign term_nxt = (tgt_nxt == lad_pkg::T_INVALID) || (tgt_nxt == lad_pkg::T_LOCAL);

	// ****************************************
	// registered routing outputs
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rt_valid <= 1'b0;
			rt_target <= 3'h0;
			rt_addr <= 36'h000000000;
			rt_write <= 1'b0;
			rt_io <= 1'b0;
			rt_rd_zero <= 1'b0;
			rt_wr_drop <= 1'b0;
		end
		else
		begin
			rt_valid <= cyc_valid;
			rt_rd_zero <= cyc_valid && term_nxt && !cyc_write; // [RL1] [RL2]
			rt_wr_drop <= cyc_valid && term_nxt && cyc_write; // [RL1] [RL2]
			if (cyc_valid)
			begin
				rt_target <= tgt_nxt;
				rt_addr <= cyc_addr;
				rt_write <= cyc_write;
				rt_io <= cyc_io;
			end
		end
	end

	// status seen by software: last destination and terminated cycle count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg.last_tgt <= 3'h0;
			cfg.term_cnt <= 8'h00;
		end
		else if (cyc_valid)
		begin
			cfg.last_tgt <= tgt_nxt;
			cfg.term_cnt <= cfg.term_cnt + 8'(term_nxt);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic mem_cpu;
	logic vid_hit;
	assign mem_cpu = cyc_valid && !cyc_io && (cyc_src == lad_pkg::SRC_CPU);
	assign vid_hit = cyc_valid && !cyc_io && lad_pkg::in_rng(cyc_addr, lad_pkg::VID_LO,
		lad_pkg::VID_HI);

	dos_to_dram_a: assert property (cyc_valid && !cyc_io && cyc_addr <= lad_pkg::DOS_HI // [RL4]
		|=> rt_valid && rt_target == lad_pkg::T_DRAM)
		else $error("dos cycle not sent to dram");

	high_local_a: assert property (cyc_valid && !cyc_io && cyc_addr >= lad_pkg::HIGH_LO // [RL2]
		|=> rt_target == lad_pkg::T_LOCAL && (rt_write ? rt_wr_drop : rt_rd_zero))
		else $error("cycle above 4 GB not terminated locally");

	invalid_zero_a: assert property (rt_valid && rt_target == lad_pkg::T_INVALID // [RL1]
		|-> (rt_write ? (rt_wr_drop && !rt_rd_zero) : (rt_rd_zero && !rt_wr_drop)))
		else $error("invalid cycle not dropped or zeroed");

	io_limit_a: assert property (cyc_valid && cyc_io && cyc_addr > lad_pkg::IO_TOP // [RL3]
		|=> rt_io && rt_target == lad_pkg::T_INVALID)
		else $error("io beyond space not invalid");

	seg_blocked_a: assert property (mem_cpu && lad_pkg::in_rng(cyc_addr, lad_pkg::SEG_LO, // [RL21]
		lad_pkg::SEG_HI) && !seg_allow |=> rt_target == lad_pkg::T_SOUTH)
		else $error("blocked segment access not forwarded south");

	shadow_dram_a: assert property (mem_cpu && cyc_addr >= lad_pkg::BIOS_LO // [RL10]
		&& cyc_addr <= lad_pkg::SEG_HI && !cyc_write && cfg.seg_re[lad_pkg::BIOS_SEG]
		|=> rt_target == lad_pkg::T_DRAM)
		else $error("shadowed bios read not sent to dram");

	bios_reset_a: assert property ($past(rst) |-> !cfg.seg_re[lad_pkg::BIOS_SEG] // [RL9]
		&& !cfg.seg_we[lad_pkg::BIOS_SEG])
		else $error("bios segment not disabled after reset");

	igu_first_a: assert property (vid_hit && cyc_src == lad_pkg::SRC_CPU && cfg.igu_en // [RL11]
		&& !(cfg.smram_en && cyc_smm) |=> rt_target == lad_pkg::T_IGU)
		else $error("internal graphics lost video precedence");

	smm_dram_a: assert property (vid_hit && cyc_src == lad_pkg::SRC_CPU && cfg.smram_en // [RL13]
		&& cyc_smm |=> rt_target == lad_pkg::T_DRAM)
		else $error("management-mode video access not sent to dram");

	gpb_abort_a: assert property (vid_hit && cyc_src == lad_pkg::SRC_GPB && cfg.smram_en // [RL14]
		&& !cfg.igu_en |=> rt_target == lad_pkg::T_ABORT)
		else $error("bridge smram cycle not aborted");

	smram_invalid_a: assert property (vid_hit && cyc_src != lad_pkg::SRC_CPU // [RL15]
		&& cfg.smram_en && cfg.igu_en |=> rt_target == lad_pkg::T_INVALID
		&& (rt_write ? rt_wr_drop : rt_rd_zero))
		else $error("non-cpu smram cycle not invalid");

	mono_io_a: assert property (cyc_valid && cyc_io && mono && !cfg.igu_en // [RL17]
		&& cfg.mono_present |=> rt_target == lad_pkg::T_SOUTH)
		else $error("mono io port not steered with mono range");

	tom_cap_a: assert property (cfg.tom <= lad_pkg::TOM_MAX) // [RL20]
		else $error("top of memory above 2 GB");

	apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one wait state");

	shadow_c: cover property (mem_cpu && cyc_addr >= lad_pkg::BIOS_LO && cfg.seg_re != 13'h0000);
	smm_c: cover property (vid_hit && cyc_smm && cfg.smram_en);
	high_c: cover property (mem_cpu && cyc_addr >= lad_pkg::HIGH_LO && !cyc_write);
	mono_c: cover property (cyc_valid && cyc_io && mono && cfg.vga_en);
endmodule

// file: testbench/lad_host.sv
// partner model: host and link side issuer of decode cycles
module lad_host (
	// clock
	input wire logic clk,
	// cycle request
	output logic cyc_valid,
	output logic [35:0] cyc_addr,
	output logic cyc_io,
	output logic cyc_write,
	output logic [1:0] cyc_src,
	output logic cyc_smm,
	// routing answer
	input wire logic rt_valid,
	input wire logic [2:0] rt_target,
	input wire logic rt_rd_zero,
	input wire logic rt_wr_drop
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cyc_valid = 1'b0;
		cyc_addr = 36'h0;
		cyc_io = 1'b0;
		cyc_write = 1'b0;
		cyc_src = 2'h0;
		cyc_smm = 1'b0;
	end
	task automatic issue(input logic [35:0] a, input logic io, input logic wr,
		input logic [1:0] src, input logic system_management_mode, output logic [2:0] tgt,
		output logic zero, output logic drop, output logic seen);
		seen = 1'b0;
		@(posedge clk);
		cyc_valid <= 1'b1;
		cyc_addr <= a;
		cyc_io <= io;
		cyc_write <= wr;
		cyc_src <= src;
		cyc_smm <= system_management_mode;
		@(posedge clk);
		cyc_valid <= 1'b0;
		// released address, write and smm lines must not keep the last value
		cyc_addr <= ~a;
		cyc_write <= ~wr;
		cyc_smm <= ~system_management_mode;
		for (int i = 0; i < 4 && !seen; i++)
		begin
			@(negedge clk);
			if (rt_valid === 1'b1)
			begin
				seen = 1'b1;
				tgt = rt_target;
				zero = rt_rd_zero;
				drop = rt_wr_drop;
			end
		end
	endtask
endmodule

// file: testbench/legacy_address_decoder_test.sv
// self-checking bench of the legacy address decoder
module legacy_address_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic cyc_valid, cyc_io, cyc_write, cyc_smm, rt_valid, rt_write, rt_io;
	logic rt_rd_zero, rt_wr_drop;
	logic [1:0] cyc_src;
	logic [35:0] cyc_addr, rt_addr;
	logic [2:0] rt_target;
	int err_total, checks;

	lad_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_io(cyc_io),
		.cyc_write(cyc_write), .cyc_src(cyc_src), .cyc_smm(cyc_smm), .rt_valid(rt_valid),
		.rt_target(rt_target), .rt_addr(rt_addr), .rt_write(rt_write), .rt_io(rt_io),
		.rt_rd_zero(rt_rd_zero), .rt_wr_drop(rt_wr_drop));
	lad_host HOST (.clk(clk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_io(cyc_io),
		.cyc_write(cyc_write), .cyc_src(cyc_src), .cyc_smm(cyc_smm), .rt_valid(rt_valid),
		.rt_target(rt_target), .rt_rd_zero(rt_rd_zero), .rt_wr_drop(rt_wr_drop));

	// ****************************************
	// reporting
	// ****************************************
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	task automatic timed_out(input string what);
		$display("wrong value %s expected answer seen none", what);
		err_total++;
		close_out();
	endtask

	// ****************************************
	// bus and cycle drivers
	// ****************************************
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		bit done;
		done = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i < 8 && !done; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
			begin
				done = 1;
				q = prdata;
				e = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
			end
		end
		if (!done)
			timed_out("pready");
	endtask
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk("write error", 36'h0, {35'h0, e});
	endtask
	task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk("read data", {4'h0, exp}, {4'h0, q});
		chk("read error", {35'h0, experr}, {35'h0, e});
	endtask
	task automatic rt(input logic [35:0] a, input logic io, input logic wr,
		input logic [1:0] src, input logic system_management_mode, input logic [2:0] t);
		logic [2:0] tgt;
		logic zero, drop, seen, bad;
		HOST.issue(a, io, wr, src, system_management_mode, tgt, zero, drop, seen);
		if (!seen)
			timed_out("rt_valid");
		bad = (t == lad_pkg::T_INVALID) || (t == lad_pkg::T_LOCAL);
		chk("target", {33'h0, t}, {33'h0, tgt});
		chk("read zero", {35'h0, bad && !wr}, {35'h0, zero});
		chk("write drop", {35'h0, bad && wr}, {35'h0, drop});
		chk("route addr", a, rt_addr);
		chk("route io", {35'h0, io}, {35'h0, rt_io});
		chk("route write", {35'h0, wr}, {35'h0, rt_write});
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_reset();
		rreg(lad_pkg::RA_SEG_RE, 32'h0, 1'b0);
		rreg(lad_pkg::RA_SEG_WE, 32'h0, 1'b0);
		rreg(12'h100, 32'h0, 1'b1);
		rt(lad_pkg::BIOS_LO, 1'b0, 1'b0, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_SOUTH);
		rt(lad_pkg::SEG_HI, 1'b0, 1'b1, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_SOUTH);
	endtask
	task automatic s_high();
		rt(lad_pkg::HIGH_LO, 1'b0, 1'b0, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_LOCAL);
		rt(36'hfffffffff, 1'b0, 1'b1, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_LOCAL);
		rt(36'h10003, 1'b1, 1'b0, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_INVALID);
		rt(36'h10003, 1'b1, 1'b1, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_INVALID);
		rt(lad_pkg::IO_TOP, 1'b1, 1'b0, lad_pkg::SRC_CPU, 1'b0, lad_pkg::T_SOUTH);
	endtask
	task automatic s_seg();
		logic [12:0] re, we;
		logic [35:0] a;
		for (int p = 0; p < 2; p++)
		begin
			// ranges never overlap: each of the twelve lower segments is its own 16 kB slot, the bios segment its own 64 kB slot
			re = p ? 13'h0f0f : 13'h0aaa;
			we = p ? 13'h0f0f : 13'h1555;
			wreg(lad_pkg::RA_SEG_RE, {19'h0, re});
			wreg(lad_pkg::RA_SEG_WE, {19'h0, we});
			rreg(lad_pkg::RA_SEG_RE, {19'h0, re}, 1'b0);
			for (int i = 0; i < 13; i++)
			begin
				a = (i < 12) ? lad_pkg::SEG_LO + (36'(i) << 14) : lad_pkg::BIOS_LO;
				a = a + ((i % 2) ? 36'h3fff : 36'h0);
				rt(a, 1'b0, 1'b0, 2'h0, 1'b0, re[i] ? 3'h0 : 3'h3);
				rt(a, 1'b0, 1'b1, 2'h0, 1'b0, we[i] ? 3'h0 : 3'h3);
			end
		end
	endtask
	task automatic s_video();
		logic [35:0] port [6] = '{36'h3b4, 36'h3b5, 36'h3b8, 36'h3b9, 36'h3ba, 36'h3bf};
		wreg(lad_pkg::RA_VIDEO, 32'h3);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_IGU);
		rt(lad_pkg::MONO_LO, 1'b0, 1'b1, 2'h0, 1'b0, lad_pkg::T_IGU);
		wreg(lad_pkg::RA_VIDEO, 32'h6);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_GPB);
		rt(lad_pkg::MONO_HI, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_SOUTH);
		for (int i = 0; i < 6; i++)
			rt(port[i], 1'b1, 1'b0, 2'h0, 1'b0, lad_pkg::T_SOUTH);
		wreg(lad_pkg::RA_VIDEO, 32'h2);
		rt(lad_pkg::MONO_LO, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_GPB);
		rt(36'h3bf, 1'b1, 1'b1, 2'h0, 1'b0, lad_pkg::T_GPB);
		wreg(lad_pkg::RA_VIDEO, 32'h0);
		rt(lad_pkg::VID_HI, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_SOUTH);
	endtask
	task automatic s_smram();
		wreg(lad_pkg::RA_VIDEO, 32'ha);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h0, 1'b1, lad_pkg::T_DRAM);
		rt(lad_pkg::VID_LO, 1'b0, 1'b1, 2'h0, 1'b0, lad_pkg::T_GPB);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h1, 1'b0, lad_pkg::T_ABORT);
		rt(lad_pkg::VID_LO, 1'b0, 1'b1, 2'h2, 1'b0, lad_pkg::T_GPB);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h2, 1'b0, lad_pkg::T_INVALID);
		wreg(lad_pkg::RA_VIDEO, 32'hb);
		rt(lad_pkg::VID_HI, 1'b0, 1'b1, 2'h0, 1'b1, lad_pkg::T_DRAM);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_IGU);
		rt(lad_pkg::VID_LO, 1'b0, 1'b1, 2'h2, 1'b0, lad_pkg::T_INVALID);
		rt(lad_pkg::VID_LO, 1'b0, 1'b0, 2'h1, 1'b0, lad_pkg::T_INVALID);
	endtask
	task automatic s_dos();
		wreg(lad_pkg::RA_VIDEO, 32'hf);
		rt(36'h0, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_DRAM);
		rt(lad_pkg::DOS_HI, 1'b0, 1'b1, 2'h2, 1'b0, lad_pkg::T_DRAM);
		wreg(lad_pkg::RA_TOM, 32'hfff);
		rreg(lad_pkg::RA_TOM, 32'h800, 1'b0);
		rt(36'h07ff00000, 1'b0, 1'b0, 2'h0, 1'b0, lad_pkg::T_DRAM);
		rt(36'h080000000, 1'b0, 1'b1, 2'h0, 1'b0, lad_pkg::T_SOUTH);
		// seven invalid or local cycles so far, last target south
		rreg(lad_pkg::RA_STAT, 32'h3b, 1'b0);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h0;
		pwdata = 32'h0;
		err_total = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_high();
		s_seg();
		s_video();
		s_smram();
		s_dos();
		close_out();
	end
endmodule
